// file: design/duh_dev.sv
// Purpose: uart end of multiplexed host port with modem pin logic
// Assumes: strobes and modem inputs asynchronous, two flop sync
// Notes: only modem control, modem status and scratch registers exist
`timescale 1ns/100ps
`default_nettype none
module duh_dev
    import duh_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // host port
    duh_if.dev bus,
    // power control
    input wire logic low_power_request_i,
    // modem inputs per channel, index 0 channel a
    input wire logic [1:0] cts_in_n_i,
    input wire logic [1:0] dsr_in_n_i,
    input wire logic [1:0] carrier_in_n_i,
    input wire logic [1:0] ring_in_n_i,
    // modem outputs
    output logic [1:0] dtr_out_n_o,
    output logic [1:0] rts_out_n_o,
    output logic [1:0] irq_out_o,
    output logic [1:0] irq_out_oe_o,
    output logic [1:0] user_out_n_o
);
    // ************************************
    // state
    // ************************************
    typedef struct packed {
        logic [1:0] lla_s1, lla_s2, cs_s1, cs_s2, rd_s1, rd_s2, wr_s1, wr_s2;
        logic [1:0] lp_s;
        logic wr_prev;
        logic [7:0] ad_s1, ad_s2;
        logic [7:0] addr;
        logic [1:0][7:0] modem_ctrl_reg;
        logic [1:0][7:0] scr;
        logic [1:0][3:0] m_s1, m_s2, m_prev;
        logic [1:0] ri_flag;
        logic [7:0] rdat;
    } duh_dev_t;
    duh_dev_t st_ff, nxt_st;
    logic lla_n, cs_n, rd_n, wr_n, lp, ch;
    logic [7:0] msr_v;

    // ************************************
    // next state
    // ************************************
    always_comb begin
        nxt_st = st_ff;
        lla_n = st_ff.lla_s2[0];
        cs_n = st_ff.cs_s2[0];
        rd_n = st_ff.rd_s2[0];
        wr_n = st_ff.wr_s2[0];
        lp = st_ff.lp_s[1];
        ch = st_ff.addr[DUH_CHSEL_BIT];
        msr_v = 8'h00;
        nxt_st.lla_s1 = {1'b0, bus.latch_address_strobe_n};
        nxt_st.lla_s2 = st_ff.lla_s1;
        nxt_st.cs_s1 = {1'b0, bus.chip_sel_n};
        nxt_st.cs_s2 = st_ff.cs_s1;
        nxt_st.rd_s1 = {1'b0, bus.read_strobe_n};
        nxt_st.rd_s2 = st_ff.rd_s1;
        nxt_st.wr_s1 = {1'b0, bus.write_strobe_n};
        nxt_st.wr_s2 = st_ff.wr_s1;
        nxt_st.lp_s = {st_ff.lp_s[0], low_power_request_i};
        nxt_st.ad_s1 = bus.ad;
        nxt_st.ad_s2 = st_ff.ad_s1;
        nxt_st.wr_prev = wr_n;
        for (int c = 0; c < 2; c++) begin
            nxt_st.m_s1[c] = {ring_in_n_i[c], carrier_in_n_i[c], dsr_in_n_i[c], cts_in_n_i[c]};
            nxt_st.m_s2[c] = st_ff.m_s1[c];
            nxt_st.m_prev[c] = st_ff.m_s2[c];
            if (st_ff.m_s2[c][3] && !st_ff.m_prev[c][3]) begin
                nxt_st.ri_flag[c] = 1'b1;
            end
        end
        if (!lla_n && !cs_n) begin
            nxt_st.addr = st_ff.ad_s2;
        end
        msr_v[DUH_MSR_CTS] = ~st_ff.m_s2[ch][0];
        msr_v[DUH_MSR_DSR] = ~st_ff.m_s2[ch][1];
        msr_v[DUH_MSR_RI] = ~st_ff.m_s2[ch][3];
        msr_v[DUH_MSR_CD] = ~st_ff.m_s2[ch][2];
        msr_v[DUH_MSR_DRI] = st_ff.ri_flag[ch];
        if (lla_n && !cs_n && !rd_n && st_ff.rd_s2[1]) begin
            unique case (st_ff.addr[2:0])
                DUH_OFS_MCR: nxt_st.rdat = st_ff.modem_ctrl_reg[ch];
                DUH_OFS_MSR: nxt_st.rdat = msr_v;
                DUH_OFS_SCR: nxt_st.rdat = st_ff.scr[ch];
                default: nxt_st.rdat = 8'h00;
            endcase
            if (st_ff.addr[2:0] == DUH_OFS_MSR) begin
                nxt_st.ri_flag[ch] = 1'b0; // read clears; new edge wins below
            end
        end
        nxt_st.rd_s2[1] = rd_n;
        for (int c = 0; c < 2; c++) begin
            if (st_ff.m_s2[c][3] && !st_ff.m_prev[c][3]) begin
                nxt_st.ri_flag[c] = 1'b1;
            end
        end
        if (lla_n && !cs_n && wr_n && !st_ff.wr_prev) begin
            unique case (st_ff.addr[2:0])
                DUH_OFS_MCR: nxt_st.modem_ctrl_reg[ch] = st_ff.ad_s2;
                DUH_OFS_SCR: nxt_st.scr[ch] = st_ff.ad_s2;
                default: ;
            endcase
        end
        if (lp) begin
            nxt_st = '0;
            nxt_st.lp_s = {st_ff.lp_s[0], low_power_request_i};
            nxt_st.lla_s1 = 2'h1;
            nxt_st.lla_s2 = 2'h1;
            nxt_st.cs_s1 = 2'h1;
            nxt_st.cs_s2 = 2'h1;
            nxt_st.rd_s1 = 2'h3;
            nxt_st.rd_s2 = 2'h3;
            nxt_st.wr_s1 = 2'h1;
            nxt_st.wr_s2 = 2'h1;
            nxt_st.wr_prev = 1'b1;
            nxt_st.m_s1 = '1;
            nxt_st.m_s2 = '1;
            nxt_st.m_prev = '1;
        end
    end

    // ************************************
    // registers
    // ************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
            st_ff.lla_s1 <= 2'h1;
            st_ff.lla_s2 <= 2'h1;
            st_ff.cs_s1 <= 2'h1;
            st_ff.cs_s2 <= 2'h1;
            st_ff.rd_s1 <= 2'h3;
            st_ff.rd_s2 <= 2'h3;
            st_ff.wr_s1 <= 2'h1;
            st_ff.wr_s2 <= 2'h1;
            st_ff.wr_prev <= 1'b1;
            st_ff.m_s1 <= '1;
            st_ff.m_s2 <= '1;
            st_ff.m_prev <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************
    // outputs
    // ************************************
    assign bus.d_ad_o = st_ff.rdat;
    assign bus.d_ad_oe = lla_n && !cs_n && !rd_n && st_ff.rd_s2[1] == 1'b0
        && !lp;
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign dtr_out_n_o[c] = ~st_ff.modem_ctrl_reg[c][DUH_MCR_DTR];
        assign rts_out_n_o[c] = ~st_ff.modem_ctrl_reg[c][DUH_MCR_RTS];
        assign irq_out_oe_o[c] = st_ff.modem_ctrl_reg[c][DUH_MCR_OUT2];
        assign irq_out_o[c] = st_ff.ri_flag[c];
        assign user_out_n_o[c] = ~st_ff.modem_ctrl_reg[c][DUH_MCR_OUT2];
    end
endmodule // duh_dev
`default_nettype wire

// file: design/duh_pkg.sv
// Purpose: shared constants for the dual uart host port and modem pins
// Assumes: single 250 MHz clock, strobes sampled through two flops
// Notes: register offsets are the low address bits, channel in bit 6
package duh_pkg;
    localparam int DUH_DW = 8;
    localparam logic [2:0] DUH_OFS_MCR = 3'h4;
    localparam logic [2:0] DUH_OFS_MSR = 3'h6;
    localparam logic [2:0] DUH_OFS_SCR = 3'h7;
    localparam int DUH_CHSEL_BIT = 6;
    localparam int DUH_MCR_DTR = 0;
    localparam int DUH_MCR_RTS = 1;
    localparam int DUH_MCR_OUT2 = 3;
    localparam int DUH_MSR_DRI = 2;
    localparam int DUH_MSR_CTS = 4;
    localparam int DUH_MSR_DSR = 5;
    localparam int DUH_MSR_RI = 6;
    localparam int DUH_MSR_CD = 7;
    localparam logic [7:0] DUH_MCR_RST = 8'h00;
    localparam logic [7:0] DUH_ADDR_RST = 8'h00;
    localparam logic [7:0] DUH_SCR_RST = 8'h00;
    // host strobe widths in cycles
    localparam int DUH_HOLD_CYC = 4;
    // host command opcodes
    localparam logic [1:0] DUH_CMD_WR = 2'h1;
    localparam logic [1:0] DUH_CMD_RD = 2'h2;
    // apb register offsets of the host controller
    localparam logic [7:0] DUH_APB_CMD = 8'h00;
    localparam logic [7:0] DUH_APB_STAT = 8'h04;
endpackage

// file: design/duh_if.sv
// Purpose: wires between host processor end and uart port end
// Assumes: tri-state bus resolved here from output enables
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface duh_if;
    logic [7:0] h_ad_o;
    logic h_ad_oe;
    logic [7:0] d_ad_o;
    logic d_ad_oe;
    logic [7:0] ad;
    logic latch_address_strobe_n;
    logic chip_sel_n;
    logic read_strobe_n;
    logic write_strobe_n;
    assign ad = d_ad_oe ? d_ad_o : (h_ad_oe ? h_ad_o : 8'hFF);
    modport host (output h_ad_o, output h_ad_oe, input ad, output latch_address_strobe_n,
        output chip_sel_n, output read_strobe_n, output write_strobe_n);
    modport dev (output d_ad_o, output d_ad_oe, input ad, input latch_address_strobe_n,
        input chip_sel_n, input read_strobe_n, input write_strobe_n);
endinterface
`default_nettype wire

// file: design/duh_host.sv
// Purpose: host processor end driving the multiplexed port from apb
// Assumes: apb slave, zero wait states, commands via one register
// Notes: write cmd word then poll status busy bit
`timescale 1ns/100ps
`default_nettype none
module duh_host
    import duh_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // port
    duh_if.host bus
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_ADDR = 3'b001, S_GAP = 3'b010, S_STRB = 3'b011, S_END = 3'b100
    } duh_hst_t;
    typedef struct packed {
        duh_hst_t fsm;
        logic [2:0] cnt;
        logic [1:0] op;
        logic [7:0] addr;
        logic [7:0] wdat;
        logic [7:0] rdat;
        logic [31:0] prdata;
    } duh_host_t;
    duh_host_t st_ff, nxt_st;
    logic acc;

    // ************************************
    // next state
    // ************************************
    always_comb begin
        nxt_st = st_ff;
        acc = psel_i && penable_i;
        if (acc && !pwrite_i) begin
            nxt_st.prdata = (paddr_i == DUH_APB_STAT)
                ? {23'h0, st_ff.fsm != S_IDLE, st_ff.rdat} : 32'h0;
        end
        unique case (st_ff.fsm)
            S_IDLE: begin
                if (acc && pwrite_i && paddr_i == DUH_APB_CMD && pwdata_i[17:16] != 2'h0) begin
                    nxt_st.op = pwdata_i[17:16];
                    nxt_st.addr = pwdata_i[15:8];
                    nxt_st.wdat = pwdata_i[7:0];
                    nxt_st.fsm = S_ADDR;
                    nxt_st.cnt = 3'h0;
                end
            end
            S_ADDR, S_GAP, S_STRB: begin
                nxt_st.cnt = st_ff.cnt + 3'h1;
                if (st_ff.cnt == 3'(DUH_HOLD_CYC - 1)) begin
                    nxt_st.cnt = 3'h0;
                    nxt_st.fsm = duh_hst_t'(st_ff.fsm + 3'h1);
                    if (st_ff.fsm == S_STRB) begin
                        nxt_st.rdat = bus.ad;
                    end
                end
            end
            S_END: nxt_st.fsm = S_IDLE;
            default: nxt_st.fsm = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************
    // outputs
    // ************************************
    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;
    assign prdata_o = nxt_st.prdata;
    assign bus.latch_address_strobe_n = st_ff.fsm != S_ADDR;
    assign bus.chip_sel_n = st_ff.fsm == S_IDLE;
    assign bus.h_ad_o = (st_ff.fsm == S_ADDR) ? st_ff.addr : st_ff.wdat;
    assign bus.h_ad_oe = st_ff.fsm == S_ADDR
        || (st_ff.op == DUH_CMD_WR && st_ff.fsm != S_IDLE);
    assign bus.read_strobe_n = !(st_ff.fsm == S_STRB && st_ff.op == DUH_CMD_RD);
    assign bus.write_strobe_n = !(st_ff.fsm == S_STRB && st_ff.op == DUH_CMD_WR);
endmodule // duh_host
`default_nettype wire

// file: test/duh_chk.sv
// Purpose: port and pin checks across the host and uart ends
// Assumes: one clock, async low reset
// Notes: instantiated beside the interface, no bind
`timescale 1ns/100ps
`default_nettype none
module duh_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // shared bus
    input wire logic [7:0] ad,
    input wire logic h_ad_oe,
    input wire logic d_ad_oe,
    input wire logic latch_address_strobe_n,
    input wire logic chip_sel_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    // modem pins
    input wire logic [1:0] dtr_out_n_o,
    input wire logic [1:0] rts_out_n_o,
    input wire logic [1:0] irq_out_oe_o,
    input wire logic [1:0] user_out_n_o
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence addr_hold;
        ($stable(ad) && !latch_address_strobe_n && h_ad_oe)[*3];
    endsequence
    sequence rd_low;
        (!read_strobe_n && !chip_sel_n)[*4] ##1 read_strobe_n;
    endsequence
    addr_phase_a: assert property ($fell(latch_address_strobe_n) |->
        !chip_sel_n && h_ad_oe && !d_ad_oe ##1 addr_hold) else $error("address phase broken");
    rd_strobe_a: assert property ($fell(read_strobe_n) |-> latch_address_strobe_n
        ##0 rd_low) else $error("read strobe shape broken");
    wr_phase_a: assert property ($fell(write_strobe_n) |-> latch_address_strobe_n &&
        !chip_sel_n && h_ad_oe ##1 (h_ad_oe && $stable(ad))[*3]) else $error("write data moved");
    rd_drive_a: assert property ($fell(read_strobe_n) |-> ##[1:4] d_ad_oe)
        else $error("read data not driven");
    bus_free_a: assert property ($rose(d_ad_oe) |-> !read_strobe_n && !chip_sel_n)
        else $error("bus driven outside a read");
    no_wr_drive_a: assert property (!write_strobe_n |-> !d_ad_oe)
        else $error("device drives during write");
    user_irq_a: assert property (user_out_n_o == ~irq_out_oe_o)
        else $error("user output and irq enable disagree");
    reset_pins_a: assert property ($rose(rst_b_i) |-> dtr_out_n_o == 2'h3 &&
        rts_out_n_o == 2'h3 && irq_out_oe_o == 2'h0) else $error("pins not at reset level");
endmodule // duh_chk
`default_nettype wire

// file: test/testbench.sv
// Purpose: host end and uart end driven from apb, pins checked
// Assumes: host answers apb with no wait, busy bit in status
// Notes: table rows cover modem control writes
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import duh_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, lp = 1'b0;
    logic [1:0] cts = 2'h3, dsr = 2'h3, cdn = 2'h3, ring = 2'h3, dtr, rts, irq, irq_oe, usr;
    logic [7:0] rv;
    logic busy;
    int n_fail = 0, checked = 0, cyc = 0;
    logic [7:0] tab [5][5] = '{'{8'h04, 8'h01, 8'h2, 8'h3, 8'h3}, '{8'h44, 8'h02, 8'h2, 8'h1, 8'h3},
        '{8'h04, 8'h08, 8'h3, 8'h1, 8'h2}, '{8'h44, 8'h0B, 8'h1, 8'h1, 8'h0},
        '{8'h04, 8'h00, 8'h1, 8'h1, 8'h1}};
    duh_if u_duh_if();
    duh_host u_duh_host(.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(), .bus(u_duh_if.host));
    duh_dev u_duh_dev(.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(u_duh_if.dev),
        .low_power_request_i(lp), .cts_in_n_i(cts), .dsr_in_n_i(dsr), .carrier_in_n_i(cdn),
        .ring_in_n_i(ring), .dtr_out_n_o(dtr), .rts_out_n_o(rts), .irq_out_o(irq),
        .irq_out_oe_o(irq_oe), .user_out_n_o(usr));
    duh_chk u_duh_chk(.clk_i(clk_i), .rst_b_i(rst_b_i), .ad(u_duh_if.ad),
        .h_ad_oe(u_duh_if.h_ad_oe), .d_ad_oe(u_duh_if.d_ad_oe),
        .latch_address_strobe_n(u_duh_if.latch_address_strobe_n),
        .chip_sel_n(u_duh_if.chip_sel_n), .read_strobe_n(u_duh_if.read_strobe_n),
        .write_strobe_n(u_duh_if.write_strobe_n), .dtr_out_n_o(dtr), .rts_out_n_o(rts),
        .irq_out_oe_o(irq_oe), .user_out_n_o(usr));
    // ****************
    // tasks
    // ****************
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rv = prdata[7:0];
        busy = prdata[8];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        apb(1'b1, DUH_APB_CMD, {14'h0, op, a, d});
        for (int i = 0; i < 100 && !done; i++) begin
            apb(1'b0, DUH_APB_STAT, 32'h0);
            done = (busy === 1'b0);
        end
        if (!done) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
        end
        // device stores a write two cycles after the host goes idle
        repeat (4) @(posedge clk_i);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            cmd(DUH_CMD_WR, tab[i][0], tab[i][1]);
            chk({6'h0, dtr}, tab[i][2]);
            chk({6'h0, rts}, tab[i][3]);
            chk({6'h0, usr}, tab[i][4]);
            chk({6'h0, irq_oe}, {6'h0, ~tab[i][4][1:0]});
        end
        cmd(DUH_CMD_RD, 8'h44, 8'h00);
        chk(rv, 8'h0B);
        cmd(DUH_CMD_WR, 8'h07, 8'hA5);
        cmd(DUH_CMD_WR, 8'h47, 8'h5A);
        cmd(DUH_CMD_RD, 8'h07, 8'h00);
        chk(rv, 8'hA5);
        cmd(DUH_CMD_RD, 8'h47, 8'h00);
        chk(rv, 8'h5A);
        cmd(DUH_CMD_RD, 8'h01, 8'h00);
        chk(rv, 8'h00);
        cts <= 2'h2;
        dsr <= 2'h1;
        cdn <= 2'h2;
        cmd(DUH_CMD_RD, 8'h06, 8'h00);
        chk(rv & 8'hF0, 8'h90);
        cmd(DUH_CMD_RD, 8'h46, 8'h00);
        chk(rv & 8'hF0, 8'h20);
        ring <= 2'h1;
        repeat (6) @(posedge clk_i);
        ring <= 2'h3;
        repeat (6) @(posedge clk_i);
        chk({7'h0, irq[1]}, 8'h01);
        cmd(DUH_CMD_RD, 8'h46, 8'h00);
        chk(rv & 8'h04, 8'h04);
        chk({7'h0, irq[1]}, 8'h00);
        lp <= 1'b1;
        repeat (8) @(posedge clk_i);
        lp <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({6'h0, dtr}, 8'h03);
        cmd(DUH_CMD_RD, 8'h07, 8'h00);
        chk(rv, DUH_SCR_RST);
        cmd(DUH_CMD_WR, 8'h44, 8'h0B);
        chk({usr, rts, dtr}, 8'h15);
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        chk({usr, rts, dtr}, 8'h3F);
        close_out();
    end
endmodule // testbench
`default_nettype wire
